// ===== timer_b_pkg.sv
// register map, field layout and counter modes of the type-B timer
// Notes on behaviour
// [R1] writing one to the capture event flag clears it; zero leaves it
// [R2] in capture modes, reading the capture register also clears the flag
// [R3] periodic, time-out and single-shot modes flag when count equals top
// [R4] frequency mode: on edge copy count, restart from zero, set flag
// [R5] capture-on-event mode flags whenever an event edge loads the capture register; a bus write to it loads it without setting the flag
// [R6] pulse-width mode: one edge restarts, opposite edge captures and flags
// [R7] frequency plus width mode flags on second active edge, counter stops
// [R8] eight-bit pwm uses low compare byte as top and flags on match
// [R9] run state bit 0 shows running, is read-only, debug cannot set it
// [R10] debug-run zero halts timer and ignores events while cpu halted
// [R11] one shared byte latch lets 16-bit values move as a whole
// [R12] count low byte at index 0x0a, high byte at next index
// [R13] bus write to count wins over a coinciding internal update
// [R14] capture value low byte at index 0x0c, high byte at next index
// [R15] a capture loads the count present at the moment of capture
// [R16] periodic, time-out and single-shot modes use capture register as top
// [R17] in eight-bit pwm the two capture bytes are independent registers
// [R18] three-bit mode field decodes the eight counter modes
// [R19] capture interrupt enable bit lets the flag raise an interrupt
// [R20] interrupt request is flag and enable, held until flag clears
`default_nettype none
package timer_b_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CONTROL_FIRST = 4'h0;
    localparam logic [3:0] IDX_CONTROL_SECOND = 4'h1;
    localparam logic [3:0] IDX_EVENT_CONTROL = 4'h4;
    localparam logic [3:0] IDX_INTERRUPT_CONTROL = 4'h5;
    localparam logic [3:0] IDX_CAPTURE_EVENT_FLAGS = 4'h6;
    localparam logic [3:0] IDX_RUN_STATE = 4'h7;
    localparam logic [3:0] IDX_DEBUG_HALT_CONTROL = 4'h8;
    localparam logic [3:0] IDX_WIDE_ACCESS_BYTE_LATCH = 4'h9;
    localparam logic [3:0] HIGH_BYTE_STEP = 4'h1;
    localparam logic [3:0] IDX_COUNTER_LOW = 4'ha;
    localparam logic [3:0] IDX_COUNTER_HIGH = IDX_COUNTER_LOW + HIGH_BYTE_STEP;
    localparam logic [3:0] IDX_CAPTURE_LOW = 4'hc;
    localparam logic [3:0] IDX_CAPTURE_HIGH = IDX_CAPTURE_LOW + HIGH_BYTE_STEP;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int EDGE_BIT = 4;
    localparam int CAPTURE_EI_BIT = 0;
    localparam int CAPTURE_IE_BIT = 0;
    localparam int CAPTURE_FLAG_BIT = 0;
    localparam int RUN_BIT = 0;
    localparam int DEBUG_RUN_BIT = 0;
    // ------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // counter modes in field order
    typedef enum logic [2:0] {
        periodic_mode,
        timeout_mode,
        capture_mode,
        frequency_mode,
        pulse_width_mode,
        freq_and_width_mode,
        single_shot_mode,
        eight_bit_pwm_mode
    } counter_mode_t;
    // phases of the frequency plus width measurement
    typedef enum logic [1:0] {
        fpw_idle,
        fpw_counting,
        fpw_captured,
        fpw_stopped
    } fpw_phase_t;
endpackage : timer_b_pkg
`default_nettype wire

// ===== timer_b_flags_count_capture_regs.sv
// type-B timer counter, capture flag and byte-latched registers on axi4-lite
`timescale 1ns/10ps
`default_nettype none
module timer_b_flags_count_capture_regs
    import timer_b_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_in,
    input wire logic debug_halt,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cap_top;
        logic [7:0] byte_latch;
        counter_mode_t mode;
        logic enable;
        logic edge_sel;
        logic capture_ei;
        logic capture_ie;
        logic capture_event_flag;
        logic run_while_halted;
        logic running;
        logic ev_prev;
        fpw_phase_t fpw;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [7:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t st;
    state_t next_st;

    // decode a byte address into {hit, index}
    function automatic logic [4:0] decode(input logic [7:0] addr);
        logic [3:0] idx;
        logic hit;
        idx = addr[5:2];
        unique case (idx)
            4'h2, 4'h3, 4'he, 4'hf: hit = 1'b0;
            default: hit = (addr[7:6] == 2'h0);
        endcase
        return {hit, idx};
    endfunction : decode

    // true for the modes that load the capture register from an edge
    function automatic logic is_capture(input counter_mode_t m);
        return (m == capture_mode) || (m == frequency_mode) ||
            (m == pulse_width_mode) || (m == freq_and_width_mode);
    endfunction : is_capture

    logic halted;
    logic ev_ok;
    logic ev_active;
    logic ev_opposite;
    logic aw_take;
    logic w_take;
    logic do_wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic [4:0] wr_dec;
    logic wr_en;
    logic do_rd;
    logic [4:0] rd_dec;
    logic count_bus_wr;
    logic cap_bus_wr;
    logic flag_set;
    logic flag_clr;
    logic [15:0] count_inc;
    logic top_hit;
    logic pwm_hit;

    // ------------------------------------------------------------
    // bus handshakes and event edges
    // ------------------------------------------------------------
    assign s_axi_awready = ~st.aw_full & ~st.bvalid;
    assign s_axi_wready = ~st.w_full & ~st.bvalid;
    assign s_axi_arready = ~st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {24'h000000, st.rdata};
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign do_wr = (st.aw_full | aw_take) & (st.w_full | w_take);
    assign wr_addr = st.aw_full ? st.aw_addr : s_axi_awaddr;
    assign wr_byte = st.w_full ? st.w_byte : s_axi_wdata[7:0];
    assign wr_lane = st.w_full ? st.w_lane : s_axi_wstrb[0];
    assign wr_dec = decode(wr_addr);
    assign wr_en = do_wr & wr_dec[4] & wr_lane;
    assign do_rd = s_axi_arvalid & s_axi_arready;
    assign rd_dec = decode(s_axi_araddr);
    assign count_bus_wr = wr_en & (wr_dec[3:0] == IDX_COUNTER_HIGH);
    assign cap_bus_wr = wr_en & ((wr_dec[3:0] == IDX_CAPTURE_HIGH) |
        ((wr_dec[3:0] == IDX_CAPTURE_LOW) & (st.mode == eight_bit_pwm_mode)));
    // debug halt freezes counting and drops events unless debug-run is set
    assign halted = debug_halt & ~st.run_while_halted; // R10
    assign ev_ok = st.capture_ei & ~halted; // R10
    assign ev_active = ev_ok & (st.edge_sel ? (st.ev_prev & ~event_in)
        : (event_in & ~st.ev_prev));
    assign ev_opposite = ev_ok & (st.edge_sel ? (event_in & ~st.ev_prev)
        : (st.ev_prev & ~event_in));
    assign count_inc = st.count + 16'h0001;
    assign top_hit = (st.count == st.cap_top); // R16
    assign pwm_hit = (st.count[7:0] == st.cap_top[7:0]); // R8
    assign irq = st.capture_event_flag & st.capture_ie; // R19 R20

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        flag_set = 1'b0;
        flag_clr = 1'b0;
        next_st.ev_prev = event_in;
        if (st.mode != freq_and_width_mode) begin
            next_st.fpw = fpw_idle;
        end
        // counting engine, one branch per mode
        if (!st.enable) begin
            next_st.running = 1'b0;
            next_st.fpw = fpw_idle;
        end else if (!halted) begin
            unique case (st.mode) // R18
                periodic_mode: begin
                    next_st.running = 1'b1;
                    if (st.running) begin
                        next_st.count = top_hit ? WORD_RESET : count_inc;
                        flag_set = top_hit; // R3
                    end
                end
                timeout_mode: begin
                    if (st.running) begin
                        next_st.count = top_hit ? WORD_RESET : count_inc;
                        flag_set = top_hit; // R3
                    end
                    if (ev_active) begin
                        next_st.running = 1'b1;
                    end else if (ev_opposite) begin
                        next_st.running = 1'b0;
                    end
                end
                capture_mode: begin
                    next_st.running = 1'b1;
                    if (st.running) begin
                        next_st.count = count_inc;
                        if (ev_active) begin
                            next_st.cap_top = st.count; // R15
                            flag_set = 1'b1; // R5
                        end
                    end
                end
                frequency_mode: begin
                    next_st.running = 1'b1;
                    if (st.running) begin
                        next_st.count = count_inc;
                        if (ev_active) begin
                            next_st.cap_top = st.count; // R4 R15
                            next_st.count = WORD_RESET; // R4
                            flag_set = 1'b1; // R4
                        end
                    end
                end
                pulse_width_mode: begin
                    next_st.running = 1'b1;
                    if (st.running) begin
                        next_st.count = count_inc;
                        if (ev_active) begin
                            next_st.count = WORD_RESET; // R6
                        end else if (ev_opposite) begin
                            next_st.cap_top = st.count; // R6 R15
                            flag_set = 1'b1; // R6
                        end
                    end
                end
                freq_and_width_mode: begin
                    unique case (st.fpw)
                        fpw_idle: begin
                            if (ev_active) begin
                                next_st.count = WORD_RESET;
                                next_st.running = 1'b1;
                                next_st.fpw = fpw_counting;
                            end
                        end
                        fpw_counting: begin
                            next_st.count = count_inc;
                            if (ev_opposite) begin
                                next_st.cap_top = st.count; // R15
                                next_st.fpw = fpw_captured;
                            end
                        end
                        fpw_captured: begin
                            next_st.count = count_inc;
                            if (ev_active) begin
                                next_st.count = st.count;
                                next_st.running = 1'b0; // R7
                                flag_set = 1'b1; // R7
                                next_st.fpw = fpw_stopped;
                            end
                        end
                        fpw_stopped: begin
                            // rearm once software has taken the result
                            if (!st.capture_event_flag) begin
                                next_st.fpw = fpw_idle;
                            end
                        end
                    endcase
                end
                single_shot_mode: begin
                    if (st.running) begin
                        next_st.count = top_hit ? WORD_RESET : count_inc;
                        flag_set = top_hit; // R3
                        next_st.running = ~top_hit;
                    end else if (ev_active) begin
                        next_st.running = 1'b1;
                    end
                end
                eight_bit_pwm_mode: begin
                    next_st.running = 1'b1;
                    if (st.running) begin
                        next_st.count = {8'h00, pwm_hit ? BYTE_RESET : count_inc[7:0]}; // R8
                        flag_set = pwm_hit; // R8
                    end
                end
            endcase
        end
        // read: answer and side effects on the shared latch
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (do_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = rd_dec[4] ? RESP_OKAY : RESP_SLVERR;
            next_st.rdata = BYTE_RESET;
            if (rd_dec[4]) begin
                unique case (rd_dec[3:0])
                    IDX_CONTROL_FIRST: next_st.rdata[ENABLE_BIT] = st.enable;
                    IDX_CONTROL_SECOND: next_st.rdata[MODE_MSB:MODE_LSB] = st.mode;
                    IDX_EVENT_CONTROL: begin
                        next_st.rdata[EDGE_BIT] = st.edge_sel;
                        next_st.rdata[CAPTURE_EI_BIT] = st.capture_ei;
                    end
                    IDX_INTERRUPT_CONTROL: next_st.rdata[CAPTURE_IE_BIT] = st.capture_ie;
                    IDX_CAPTURE_EVENT_FLAGS: begin
                        next_st.rdata[CAPTURE_FLAG_BIT] = st.capture_event_flag;
                    end
                    IDX_RUN_STATE: next_st.rdata[RUN_BIT] = st.running; // R9
                    IDX_DEBUG_HALT_CONTROL: begin
                        next_st.rdata[DEBUG_RUN_BIT] = st.run_while_halted;
                    end
                    IDX_WIDE_ACCESS_BYTE_LATCH: next_st.rdata = st.byte_latch; // R11
                    IDX_COUNTER_LOW: begin
                        next_st.rdata = st.count[7:0]; // R12
                        next_st.byte_latch = st.count[15:8]; // R11
                    end
                    IDX_COUNTER_HIGH: next_st.rdata = st.byte_latch; // R12
                    IDX_CAPTURE_LOW: begin
                        next_st.rdata = st.cap_top[7:0]; // R14
                        if (st.mode != eight_bit_pwm_mode) begin
                            next_st.byte_latch = st.cap_top[15:8]; // R11
                        end
                        flag_clr = is_capture(st.mode); // R2
                    end
                    default: begin
                        next_st.rdata = (st.mode == eight_bit_pwm_mode) ?
                            st.cap_top[15:8] : st.byte_latch; // R14 R17
                    end
                endcase
            end
        end
        // write: hold address and data until both are in
        next_st.aw_full = (st.aw_full | aw_take) & ~do_wr;
        next_st.w_full = (st.w_full | w_take) & ~do_wr;
        if (aw_take) begin
            next_st.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            next_st.w_byte = s_axi_wdata[7:0];
            next_st.w_lane = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (do_wr) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_dec[4] ? RESP_OKAY : RESP_SLVERR;
        end
        // register writes other than the flag clear land last so they win over the engine
        if (wr_en) begin
            unique case (wr_dec[3:0])
                IDX_CONTROL_FIRST: next_st.enable = wr_byte[ENABLE_BIT];
                IDX_CONTROL_SECOND: begin
                    next_st.mode = counter_mode_t'(wr_byte[MODE_MSB:MODE_LSB]); // R18
                end
                IDX_EVENT_CONTROL: begin
                    next_st.edge_sel = wr_byte[EDGE_BIT];
                    next_st.capture_ei = wr_byte[CAPTURE_EI_BIT];
                end
                IDX_INTERRUPT_CONTROL: next_st.capture_ie = wr_byte[CAPTURE_IE_BIT]; // R19
                IDX_CAPTURE_EVENT_FLAGS: flag_clr = flag_clr | wr_byte[CAPTURE_FLAG_BIT]; // R1
                IDX_RUN_STATE: next_st.running = next_st.running; // R9
                IDX_DEBUG_HALT_CONTROL: begin
                    next_st.run_while_halted = wr_byte[DEBUG_RUN_BIT]; // R10
                end
                IDX_WIDE_ACCESS_BYTE_LATCH: next_st.byte_latch = wr_byte; // R11
                IDX_COUNTER_LOW: next_st.byte_latch = wr_byte; // R11 R12
                IDX_COUNTER_HIGH: next_st.count = {wr_byte, st.byte_latch}; // R12 R13
                IDX_CAPTURE_LOW: begin
                    if (st.mode == eight_bit_pwm_mode) begin
                        next_st.cap_top[7:0] = wr_byte; // R17
                    end else begin
                        next_st.byte_latch = wr_byte; // R11 R14
                    end
                end
                default: begin
                    if (st.mode == eight_bit_pwm_mode) begin
                        next_st.cap_top[15:8] = wr_byte; // R17
                    end else begin
                        next_st.cap_top = {wr_byte, st.byte_latch}; // R14
                    end
                end
            endcase
        end
        // hardware set wins over a clear in the same cycle
        next_st.capture_event_flag = (st.capture_event_flag & ~flag_clr) | flag_set; // R1 R2
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_flag_write_clear: assert property ( // R1
        (wr_en && wr_dec[3:0] == IDX_CAPTURE_EVENT_FLAGS && wr_byte[0] && !flag_set)
        |=> !st.capture_event_flag
    ) else $error("flag survived a write of one");

    a_read_clear_flag: assert property ( // R2
        (do_rd && rd_dec[4] && rd_dec[3:0] == IDX_CAPTURE_LOW && is_capture(st.mode)
        && !flag_set) |=> !st.capture_event_flag
    ) else $error("capture read did not clear flag");

    a_top_match_flag: assert property ( // R3
        (st.mode == periodic_mode && st.enable && st.running && !halted && top_hit
        && !count_bus_wr) |=> (st.capture_event_flag && st.count == 16'h0000)
    ) else $error("periodic top match missed");

    a_freq_restart: assert property ( // R4
        (st.mode == frequency_mode && st.enable && st.running && ev_active
        && !count_bus_wr && !cap_bus_wr)
        |=> (st.capture_event_flag && st.cap_top == $past(st.count)
        && st.count == 16'h0000)
    ) else $error("frequency capture wrong");

    a_width_capture: assert property ( // R6
        (st.mode == pulse_width_mode && st.enable && st.running && ev_opposite
        && !ev_active && !count_bus_wr && !cap_bus_wr)
        |=> (st.capture_event_flag && st.cap_top == $past(st.count)
        && st.count == $past(st.count) + 16'h0001)
    ) else $error("pulse width capture wrong");

    a_second_edge_stop: assert property ( // R7
        (st.mode == freq_and_width_mode && st.enable && !halted
        && st.fpw == fpw_captured && ev_active)
        |=> (st.capture_event_flag && !st.running)
    ) else $error("second edge did not stop counter");

    a_pwm_low_top: assert property ( // R8
        (st.mode == eight_bit_pwm_mode && st.enable && st.running && !halted
        && pwm_hit && !count_bus_wr) |=> (st.capture_event_flag && st.count == 16'h0000)
    ) else $error("pwm low byte top missed");

    a_run_state_read: assert property ( // R9
        (do_rd && rd_dec[4] && rd_dec[3:0] == IDX_RUN_STATE)
        |=> (s_axi_rvalid && s_axi_rdata[0] == $past(st.running))
    ) else $error("run state read wrong");

    a_debug_freeze: assert property ( // R10
        (halted && !count_bus_wr) |=> st.count == $past(st.count)
    ) else $error("count moved while halted");

    a_count_write_wins: assert property ( // R13
        count_bus_wr |=> st.count == {$past(wr_byte), $past(st.byte_latch)}
    ) else $error("count write lost to engine");

    a_irq_drop: assert property ( // R20
        (flag_clr && !flag_set) |=> !irq
    ) else $error("interrupt held after clear");
endmodule : timer_b_flags_count_capture_regs
`default_nettype wire

// ===== timer_b_flags_count_capture_regs_test.sv
// self-checking bench of the type-B timer register block
`timescale 1ns/10ps
`default_nettype none
module timer_b_flags_count_capture_regs_test;
import timer_b_pkg::*;
logic clk = '0, arst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
logic s_axi_arvalid = '0, s_axi_rready = '0, event_in = '0, debug_halt = '0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, rd2;
logic [3:0] s_axi_wstrb = '0;
logic [1:0] s_axi_bresp, s_axi_rresp, rs;
int num_errors = 0, total_checks = 0, top, i;
always #10 clk = ~clk;
timer_b_flags_count_capture_regs u_timer_b_flags_count_capture_regs (.clk, .arst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .event_in, .debug_halt, .irq);
// ------------------------------------------------------------
// bus tasks and compare
// ------------------------------------------------------------
task give_verdict;
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask : give_verdict
task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
        num_errors++;
        $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
endtask : chk
task tmo;
    num_errors++;
    $display("wrong value at %0t: no answer", $time);
    give_verdict();
endtask : tmo
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'h0;
            return;
        end
    end
    tmo();
endtask : wr
task automatic rdt(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid) begin
            s_axi_rready <= 1'h0;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            return;
        end
    end
    tmo();
endtask : rdt
task automatic wirq;
    for (int n = 0; n < 300; n++) begin
        @(posedge clk);
        if (irq === 1'h1) return;
    end
    tmo();
endtask : wirq
// ------------------------------------------------------------
// stimulus
// ------------------------------------------------------------
initial begin
    i = $urandom(32'hfd97a254);
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    // reset values of run state up to capture low
    for (i = 7; i < 13; i++) begin
        rdt(8'(i * 4));
        chk(rd, 32'h0);
    end
    rdt(8'h08);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'h08, 8'h00);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    // every counter mode code round trip
    for (i = 0; i < 8; i++) begin
        wr(8'h04, 8'(i));
        rdt(8'h04);
        chk(rd, 32'(i));
    end
    wr(8'h04, 8'h00);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    top = 40 + $urandom % 16;
    wr(8'h24, 8'(top));
    rdt(8'h24);
    chk(rd, 32'(top));
    // periodic flag at top, irq, clear
    wr(8'h30, 8'(top));
    wr(8'h34, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h00, 8'h01);
    wirq();
    rdt(8'h18);
    chk(rd, 32'h1);
    rdt(8'h1c);
    chk(rd, 32'h1);
    wr(8'h1c, 8'h00);
    rdt(8'h1c);
    chk(rd, 32'h1);
    // far top first, so no new match can race the flag clear
    wr(8'h34, 8'hff);
    wr(8'h18, 8'h00);
    chk(32'(irq), 32'h1);
    wr(8'h18, 8'h01);
    chk(32'(irq), 32'h0);
    // halted counter freezes unless run while halted
    @(posedge clk) debug_halt <= 1'h1;
    rdt(8'h28);
    rd2 = rd;
    rdt(8'h28);
    chk(rd, rd2);
    wr(8'h20, 8'h01);
    rdt(8'h28);
    rd2 = rd;
    rdt(8'h28);
    chk(32'(rd == rd2), 32'h0);
    @(posedge clk) debug_halt <= 1'h0;
    wr(8'h00, 8'h00);
    rdt(8'h1c);
    chk(rd, 32'h0);
    // capture of a loaded count on an event edge
    wr(8'h28, 8'h00);
    wr(8'h2c, 8'h12);
    rdt(8'h28);
    rdt(8'h2c);
    chk(rd, 32'h12);
    wr(8'h04, 8'h02);
    wr(8'h10, 8'h01);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h01);
    @(posedge clk) event_in <= 1'h1;
    repeat (2) @(posedge clk);
    event_in <= 1'h0;
    wirq();
    rdt(8'h30);
    rdt(8'h34);
    chk(rd, 32'h12);
    rdt(8'h18);
    chk(rd, 32'h0);
    // bus write beats the running count
    wr(8'h28, 8'h00);
    wr(8'h2c, 8'h34);
    rdt(8'h28);
    rdt(8'h2c);
    chk(rd, 32'h34);
    // eight-bit pwm: low byte is top, high byte stands alone
    wr(8'h04, 8'h07);
    wr(8'h30, 8'h10);
    wr(8'h34, 8'h5a);
    wirq();
    rdt(8'h18);
    chk(rd, 32'h1);
    rdt(8'h30);
    chk(rd, 32'h10);
    rdt(8'h34);
    chk(rd, 32'h5a);
    // frequency: edge captures and restarts the count from zero
    wr(8'h04, 8'h03);
    wr(8'h18, 8'h01);
    @(posedge clk) event_in <= 1'h1;
    wirq();
    event_in <= 1'h0;
    rdt(8'h28);
    chk(rd, 32'h2);
    // pulse width: rise restarts, fall captures while counting goes on
    wr(8'h04, 8'h04);
    wr(8'h18, 8'h01);
    @(posedge clk) event_in <= 1'h1;
    repeat (5) @(posedge clk);
    event_in <= 1'h0;
    wirq();
    rdt(8'h30);
    chk(rd, 32'h4);
    rdt(8'h18);
    chk(rd, 32'h0);
    give_verdict();
end
endmodule : timer_b_flags_count_capture_regs_test
`default_nettype wire
